// ### shared/sltc_pkg.sv
// constants for the sink link training and configuration register set
`default_nettype none
package sltc_pkg;
	localparam int ADDR_W = 20;
	// register addresses
	localparam logic [19:0] ADDR_LINK_RATE = 20'h0_0100;
	localparam logic [19:0] ADDR_LANE_WIDTH = 20'h0_0101;
	localparam logic [19:0] ADDR_TRAINING = 20'h0_0102;
	localparam logic [19:0] ADDR_DRIVE_BASE = 20'h0_0103;
	localparam logic [19:0] ADDR_LANES_LOW = 20'h0_0202;
	localparam logic [19:0] ADDR_LANES_HIGH = 20'h0_0203;
	localparam logic [19:0] ADDR_ALIGN = 20'h0_0204;
	localparam logic [19:0] ADDR_SYNC = 20'h0_0205;
	localparam logic [19:0] ADDR_REQ_LOW = 20'h0_0206;
	localparam logic [19:0] ADDR_REQ_HIGH = 20'h0_0207;
	localparam int DRIVE_LANES = 4;
	// values after reset
	localparam logic [7:0] RST_LINK_RATE = 8'h06;
	localparam logic [7:0] RST_LANE_WIDTH = 8'h01;
	localparam logic [7:0] RST_TRAINING = 8'h00;
	localparam logic [7:0] RST_DRIVE = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	// link rate codes, rate = code x 0.27 Gb/s
	localparam logic [7:0] RATE_1G62 = 8'h06;
	localparam logic [7:0] RATE_2G70 = 8'h0A;
	// lane count codes
	localparam logic [4:0] LANES_ONE = 5'h01;
	localparam logic [4:0] LANES_TWO = 5'h02;
	localparam logic [4:0] LANES_FOUR = 5'h04;
	// field positions
	localparam int LW_COUNT_MSB = 4;
	localparam int LW_ENH_FRAME = 7;
	localparam int TP_PAT_LSB = 0;
	localparam int TP_QUAL_LSB = 2;
	localparam int TP_RCLK_EN = 4;
	localparam int TP_SCR_BYP = 5;
	localparam int TP_ERRSEL_LSB = 6;
	localparam int AL_ALIGNED = 0;
	localparam int AL_DS_CHANGE = 6;
	localparam int AL_UPDATED = 7;
	// write masks: reserved bits store zero
	localparam logic [7:0] LW_MASK_REV11 = 8'h9F;
	localparam logic [7:0] LW_MASK_REV10 = 8'h1F;
	localparam logic [7:0] TP_MASK_REV11 = 8'hFF;
	localparam logic [7:0] TP_MASK_REV10 = 8'h3F;
	localparam logic [7:0] DRIVE_MASK = 8'h3F;
	localparam logic [1:0] RESERVED_CODE = 2'h3;
endpackage
`default_nettype wire

// ### verilog/sltc_lane_pair.sv
// status and drive request bytes for one pair of lanes
`default_nettype none
module sltc_lane_pair (
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// per-lane receiver state, lane a in index 0, lane b in index 1
	input wire logic [1:0] clock_recovered_in,
	input wire logic [1:0] equalized_in,
	input wire logic [1:0] symbol_lock_in,
	input wire logic [3:0] swing_request_in,
	input wire logic [3:0] emphasis_request_in,
	// packed bytes
	output logic [7:0] state_byte_out,
	output logic [7:0] request_byte_out,
	output logic changed_out
);
	logic [7:0] state_next;
	logic [7:0] request_next;

	always_comb begin
		state_next = {1'b0, symbol_lock_in[1], equalized_in[1], clock_recovered_in[1],
			1'b0, symbol_lock_in[0], equalized_in[0], clock_recovered_in[0]};
		request_next = {emphasis_request_in[3:2], swing_request_in[3:2],
			emphasis_request_in[1:0], swing_request_in[1:0]};
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			state_byte_out <= 8'h00;
			request_byte_out <= 8'h00;
			changed_out <= 1'b0;
		end else begin
			state_byte_out <= state_next;
			request_byte_out <= request_next;
			changed_out <= (state_next != state_byte_out) || (request_next != request_byte_out);
		end
	end

	property p_pair_reserved_zero;
		@(posedge mclk_in) disable iff (srst_in)
			state_byte_out[3] == 1'b0 && state_byte_out[7] == 1'b0;
	endproperty
	a_pair_reserved_zero: assert property (p_pair_reserved_zero) else $error("status reserved bit set");

	property p_pair_request_follows;
		@(posedge mclk_in) disable iff (srst_in)
			1'b1 |=> request_byte_out[5:4] == $past(swing_request_in[3:2])
				&& request_byte_out[3:2] == $past(emphasis_request_in[1:0]);
	endproperty
	a_pair_request_follows: assert property (p_pair_request_follows) else $error("request layout wrong");
endmodule
`default_nettype wire

// ### verilog/sltc_regs.sv
// sink link configuration and training status registers
`default_nettype none
module sltc_regs #(
	parameter bit REV_1_1 = 1'b1
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// auxiliary channel register port
	input wire logic [sltc_pkg::ADDR_W-1:0] aux_addr_in,
	input wire logic aux_wr_in,
	input wire logic aux_rd_in,
	input wire logic [7:0] aux_wdata_in,
	output logic [7:0] aux_rdata_out,
	output logic aux_rvalid_out,
	// receiver state, lane index 0..3
	input wire logic [3:0] lane_clock_recovered_in,
	input wire logic [3:0] lane_equalized_in,
	input wire logic [3:0] lane_symbol_lock_in,
	input wire logic [7:0] lane_swing_request_in,
	input wire logic [7:0] lane_emphasis_request_in,
	input wire logic cross_lane_aligned_in,
	input wire logic downstream_change_in,
	input wire logic [1:0] port_in_sync_in,
	// link configuration towards the receiver
	output logic [7:0] link_rate_select_out,
	output logic link_rate_valid_out,
	output logic [3:0] active_lanes_out,
	output logic lane_count_valid_out,
	output logic enhanced_framing_out,
	output logic [1:0] training_pattern_out,
	output logic [1:0] quality_pattern_out,
	output logic recovered_clock_en_out,
	output logic scrambler_bypass_out,
	output logic [1:0] error_count_sel_out,
	output logic [31:0] drive_settings_out
);
	import sltc_pkg::*;

	logic [7:0] link_rate_select_reg;
	logic [7:0] lane_width_and_framing_reg;
	logic [7:0] training_pattern_select_reg;
	logic [7:0] drive_setting_reg [DRIVE_LANES];
	logic [7:0] lanes_low_pair_state;
	logic [7:0] lanes_high_pair_state;
	logic [7:0] drive_request_low_pair;
	logic [7:0] drive_request_high_pair;
	logic low_changed;
	logic high_changed;
	logic aligned_reg;
	logic ds_change_reg;
	logic updated_reg;
	logic [1:0] sync_reg;
	logic [7:0] rdata_next;
	logic align_read;
	logic [7:0] lw_mask;
	logic [7:0] tp_mask;

	assign lw_mask = REV_1_1 ? LW_MASK_REV11 : LW_MASK_REV10;
	assign tp_mask = REV_1_1 ? TP_MASK_REV11 : TP_MASK_REV10;
	assign align_read = aux_rd_in && aux_addr_in == ADDR_ALIGN;

	sltc_lane_pair u_low_pair (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.clock_recovered_in(lane_clock_recovered_in[1:0]),
		.equalized_in(lane_equalized_in[1:0]),
		.symbol_lock_in(lane_symbol_lock_in[1:0]),
		.swing_request_in(lane_swing_request_in[3:0]),
		.emphasis_request_in(lane_emphasis_request_in[3:0]),
		.state_byte_out(lanes_low_pair_state),
		.request_byte_out(drive_request_low_pair),
		.changed_out(low_changed)
	);

	sltc_lane_pair u_high_pair (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.clock_recovered_in(lane_clock_recovered_in[3:2]),
		.equalized_in(lane_equalized_in[3:2]),
		.symbol_lock_in(lane_symbol_lock_in[3:2]),
		.swing_request_in(lane_swing_request_in[7:4]),
		.emphasis_request_in(lane_emphasis_request_in[7:4]),
		.state_byte_out(lanes_high_pair_state),
		.request_byte_out(drive_request_high_pair),
		.changed_out(high_changed)
	);

	// source-written configuration; status addresses have no write path
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			link_rate_select_reg <= RST_LINK_RATE;
			lane_width_and_framing_reg <= RST_LANE_WIDTH;
			training_pattern_select_reg <= RST_TRAINING;
		end else if (aux_wr_in) begin
			if (aux_addr_in == ADDR_LINK_RATE)
				link_rate_select_reg <= aux_wdata_in;
			if (aux_addr_in == ADDR_LANE_WIDTH)
				lane_width_and_framing_reg <= aux_wdata_in & lw_mask;
			if (aux_addr_in == ADDR_TRAINING)
				training_pattern_select_reg <= aux_wdata_in & tp_mask;
		end
	end

	for (genvar i = 0; i < DRIVE_LANES; i++) begin : g_drive
		always_ff @(posedge mclk_in) begin
			if (srst_in)
				drive_setting_reg[i] <= RST_DRIVE;
			else if (aux_wr_in && aux_addr_in == ADDR_DRIVE_BASE + 20'(i))
				drive_setting_reg[i] <= aux_wdata_in & DRIVE_MASK;
		end
		assign drive_settings_out[8*i +: 8] = drive_setting_reg[i];
	end

	// alignment and sync follow their inputs; for downstream change and update flags a set beats a read clear
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			aligned_reg <= 1'b0;
			sync_reg <= 2'b00;
		end else begin
			aligned_reg <= cross_lane_aligned_in;
			sync_reg <= port_in_sync_in;
		end
	end

	// bit 6 is sticky like bit 7 and cleared by the same read
	always_ff @(posedge mclk_in) begin
		if (srst_in)
			ds_change_reg <= 1'b0;
		else if (downstream_change_in)
			ds_change_reg <= 1'b1;
		else if (align_read)
			ds_change_reg <= 1'b0;
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in)
			updated_reg <= 1'b0;
		else if (low_changed || high_changed)
			updated_reg <= 1'b1;
		else if (align_read)
			updated_reg <= 1'b0;
	end

	// read mux
	always_comb begin
		rdata_next = UNMAPPED_DATA;
		unique case (aux_addr_in)
			ADDR_LINK_RATE: rdata_next = link_rate_select_reg;
			ADDR_LANE_WIDTH: rdata_next = lane_width_and_framing_reg;
			ADDR_TRAINING: rdata_next = training_pattern_select_reg;
			ADDR_DRIVE_BASE: rdata_next = drive_setting_reg[0];
			ADDR_DRIVE_BASE + 20'h0_0001: rdata_next = drive_setting_reg[1];
			ADDR_DRIVE_BASE + 20'h0_0002: rdata_next = drive_setting_reg[2];
			ADDR_DRIVE_BASE + 20'h0_0003: rdata_next = drive_setting_reg[3];
			ADDR_LANES_LOW: rdata_next = lanes_low_pair_state;
			ADDR_LANES_HIGH: rdata_next = lanes_high_pair_state;
			ADDR_ALIGN: rdata_next = {updated_reg, ds_change_reg, 5'b0_0000, aligned_reg};
			ADDR_SYNC: rdata_next = {6'b00_0000, sync_reg};
			ADDR_REQ_LOW: rdata_next = drive_request_low_pair;
			ADDR_REQ_HIGH: rdata_next = drive_request_high_pair;
			default: rdata_next = UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			aux_rdata_out <= 8'h00;
			aux_rvalid_out <= 1'b0;
		end else begin
			aux_rvalid_out <= aux_rd_in;
			if (aux_rd_in)
				aux_rdata_out <= rdata_next;
		end
	end

	// decoded configuration
	always_comb begin
		link_rate_select_out = link_rate_select_reg;
		link_rate_valid_out = link_rate_select_reg == RATE_1G62
			|| link_rate_select_reg == RATE_2G70;
		unique case (lane_width_and_framing_reg[LW_COUNT_MSB:0])
			LANES_ONE: active_lanes_out = 4'h1;
			LANES_TWO: active_lanes_out = 4'h3;
			LANES_FOUR: active_lanes_out = 4'hF;
			default: active_lanes_out = 4'h0;
		endcase
		lane_count_valid_out = active_lanes_out != 4'h0;
		enhanced_framing_out = lane_width_and_framing_reg[LW_ENH_FRAME];
		training_pattern_out = training_pattern_select_reg[TP_PAT_LSB +: 2];
		quality_pattern_out = training_pattern_select_reg[TP_QUAL_LSB +: 2];
		recovered_clock_en_out = training_pattern_select_reg[TP_RCLK_EN];
		scrambler_bypass_out = training_pattern_select_reg[TP_SCR_BYP];
		error_count_sel_out = training_pattern_select_reg[TP_ERRSEL_LSB +: 2];
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	sequence s_read(logic [19:0] a);
		aux_rd_in && aux_addr_in == a;
	endsequence

	sequence s_write(logic [19:0] a);
		aux_wr_in && aux_addr_in == a;
	endsequence

	property p_low_layout;
		s_read(ADDR_LANES_LOW) |=> aux_rvalid_out && aux_rdata_out[3] == 1'b0
			&& aux_rdata_out[7] == 1'b0 && aux_rdata_out == $past(lanes_low_pair_state);
	endproperty
	a_low_layout: assert property (p_low_layout) else $error("low pair read wrong");

	property p_high_layout;
		s_read(ADDR_LANES_HIGH) |=> aux_rvalid_out && !aux_rdata_out[3] && !aux_rdata_out[7]
			&& aux_rdata_out == $past(lanes_high_pair_state);
	endproperty
	a_high_layout: assert property (p_high_layout) else $error("high pair read wrong");

	property p_align_read;
		s_read(ADDR_ALIGN) |=> aux_rdata_out[5:1] == 5'b0_0000
			&& aux_rdata_out[0] == $past(aligned_reg);
	endproperty
	a_align_read: assert property (p_align_read) else $error("alignment byte wrong");

	property p_ds_change;
		downstream_change_in |=> ds_change_reg;
	endproperty
	a_ds_change: assert property (p_ds_change) else $error("downstream change lost");

	property p_update_clear;
		s_read(ADDR_ALIGN) && !low_changed && !high_changed |=> !updated_reg;
	endproperty
	a_update_clear: assert property (p_update_clear) else $error("update flag not cleared");

	property p_update_set;
		(low_changed || high_changed) |=> updated_reg;
	endproperty
	a_update_set: assert property (p_update_set) else $error("update flag not set");

	property p_sync;
		s_read(ADDR_SYNC) |=> aux_rdata_out[7:2] == 6'b00_0000;
	endproperty
	a_sync: assert property (p_sync) else $error("sink status reserved set");

	property p_sync_bits;
		s_read(ADDR_SYNC) |=> aux_rdata_out[1:0] == $past(sync_reg);
	endproperty
	a_sync_bits: assert property (p_sync_bits) else $error("sink sync bits wrong");

	property p_rate_valid;
		s_write(ADDR_LINK_RATE) ##0 aux_wdata_in == RATE_2G70
			|=> link_rate_valid_out && link_rate_select_out == RATE_2G70;
	endproperty
	a_rate_valid: assert property (p_rate_valid) else $error("rate validity wrong");

	property p_lane_write;
		s_write(ADDR_LANE_WIDTH) ##0 aux_wdata_in[4:0] == LANES_TWO |=> active_lanes_out == 4'h3;
	endproperty
	a_lane_write: assert property (p_lane_write) else $error("two lanes not decoded");

	property p_training_write;
		s_write(ADDR_TRAINING) |=> training_pattern_out == $past(aux_wdata_in[1:0])
			&& recovered_clock_en_out == $past(aux_wdata_in[4])
			&& scrambler_bypass_out == $past(aux_wdata_in[5]);
	endproperty
	a_training_write: assert property (p_training_write) else $error("training byte wrong");

	property p_drive_reserved;
		s_read(ADDR_DRIVE_BASE) |=> aux_rdata_out[7:6] == 2'b00;
	endproperty
	a_drive_reserved: assert property (p_drive_reserved) else $error("drive reserved set");

	property p_status_readonly;
		aux_wr_in && (aux_addr_in == ADDR_LANES_LOW || aux_addr_in == ADDR_REQ_LOW)
			|=> $stable(link_rate_select_reg) && $stable(lane_width_and_framing_reg)
			&& $stable(training_pattern_select_reg);
	endproperty
	a_status_readonly: assert property (p_status_readonly) else $error("status write changed state");
endmodule
`default_nettype wire

// ### verif/sltc_source_model.sv
// source side model driving the auxiliary register port
`default_nettype none
module sltc_source_model (
	// clock
	input wire logic mclk_in,
	// register port towards the sink
	output logic [sltc_pkg::ADDR_W-1:0] aux_addr_out,
	output logic aux_wr_out,
	output logic aux_rd_out,
	output logic [7:0] aux_wdata_out,
	input wire logic [7:0] aux_rdata_in,
	input wire logic aux_rvalid_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import sltc_pkg::*;
	// advertised receiver capability; callers keep rate and lanes within it
	localparam logic [7:0] CAP_RATE = RATE_2G70;
	localparam logic [4:0] CAP_LANES = LANES_FOUR;
	initial begin
		aux_addr_out = '0;
		aux_wr_out = 1'b0;
		aux_rd_out = 1'b0;
		aux_wdata_out = 8'h00;
	end
	task automatic write_byte(input logic [19:0] addr, input logic [7:0] data);
		@(posedge mclk_in);
		aux_addr_out <= addr;
		aux_wdata_out <= data;
		aux_wr_out <= 1'b1;
		@(posedge mclk_in);
		aux_wr_out <= 1'b0;
		// released lines carry junk, not the last value
		aux_wdata_out <= ~data;
		aux_addr_out <= ~addr;
	endtask
	task automatic read_byte(input logic [19:0] addr, output logic [7:0] data, output logic ok);
		ok = 1'b0;
		data = 8'h00;
		@(posedge mclk_in);
		aux_addr_out <= addr;
		aux_rd_out <= 1'b1;
		@(posedge mclk_in);
		aux_rd_out <= 1'b0;
		aux_addr_out <= ~addr;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge mclk_in);
			if (aux_rvalid_in === 1'b1) begin
				data = aux_rdata_in;
				ok = 1'b1;
			end
		end
	endtask
endmodule
`default_nettype wire

// ### verif/sltc_regs_bench.sv
// self-checking bench for the link configuration registers
`default_nettype none
module sltc_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import sltc_pkg::*;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [19:0] addr;
	logic wr, rd;
	logic [7:0] wdata, rdata;
	logic rvalid;
	logic [3:0] cr = 4'h0, eq = 4'h0, sl = 4'h0;
	logic [7:0] swing = 8'h00, emph = 8'h00;
	logic aligned = 1'b0, ds = 1'b0;
	logic [1:0] sync = 2'b00;
	logic [7:0] rate;
	logic rate_ok, lane_ok, enh, rclk, scr;
	logic [3:0] lanes;
	logic [1:0] tpat, qpat, esel;
	logic [31:0] drive;
	int failures = 0;
	int checks = 0;
	sltc_regs #(.REV_1_1(1'b1)) u_dut (.mclk_in(mclk_in), .srst_in(srst_in),
		.aux_addr_in(addr), .aux_wr_in(wr), .aux_rd_in(rd), .aux_wdata_in(wdata),
		.aux_rdata_out(rdata), .aux_rvalid_out(rvalid),
		.lane_clock_recovered_in(cr), .lane_equalized_in(eq), .lane_symbol_lock_in(sl),
		.lane_swing_request_in(swing), .lane_emphasis_request_in(emph),
		.cross_lane_aligned_in(aligned), .downstream_change_in(ds), .port_in_sync_in(sync),
		.link_rate_select_out(rate), .link_rate_valid_out(rate_ok), .active_lanes_out(lanes),
		.lane_count_valid_out(lane_ok), .enhanced_framing_out(enh), .training_pattern_out(tpat),
		.quality_pattern_out(qpat), .recovered_clock_en_out(rclk), .scrambler_bypass_out(scr),
		.error_count_sel_out(esel), .drive_settings_out(drive));
	sltc_source_model u_src (.mclk_in(mclk_in), .aux_addr_out(addr), .aux_wr_out(wr),
		.aux_rd_out(rd), .aux_wdata_out(wdata), .aux_rdata_in(rdata), .aux_rvalid_in(rvalid));
	initial begin
		forever #25 mclk_in = ~mclk_in;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// read a register and compare against the expected byte
	task automatic rd_chk(input string name, input logic [19:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_src.read_byte(a, d, ok);
		check({name, " answered"}, ok, 1'b1);
		check(name, d, exp);
	endtask
	task automatic wr_settle(input logic [19:0] a, input logic [7:0] d);
		u_src.write_byte(a, d);
		@(negedge mclk_in);
	endtask
	task automatic t_reset();
		rd_chk("rate", ADDR_LINK_RATE, RST_LINK_RATE);
		rd_chk("lane byte", ADDR_LANE_WIDTH, RST_LANE_WIDTH);
		rd_chk("training", ADDR_TRAINING, RST_TRAINING);
		rd_chk("drive0", ADDR_DRIVE_BASE, RST_DRIVE);
		wr_settle(20'h0_0300, 8'h5A);
		rd_chk("unmapped", 20'h0_0300, UNMAPPED_DATA);
		check("lanes after reset", lanes, 4'h1);
	endtask
	task automatic t_rate();
		wr_settle(ADDR_LINK_RATE, RATE_2G70);
		check("rate valid", {rate_ok, rate}, {1'b1, RATE_2G70});
		wr_settle(ADDR_LINK_RATE, 8'h07);
		check("rate reserved", {rate_ok, rate}, {1'b0, 8'h07});
		wr_settle(ADDR_LINK_RATE, RATE_1G62);
		check("rate low", {rate_ok, rate}, {1'b1, RATE_1G62});
		rd_chk("rate back", ADDR_LINK_RATE, RATE_1G62);
	endtask
	task automatic t_lanes();
		logic [4:0] codes [3] = '{LANES_ONE, LANES_TWO, LANES_FOUR};
		logic [3:0] masks [3] = '{4'h1, 4'h3, 4'hF};
		for (int k = 0; k < 3; k++) begin
			wr_settle(ADDR_LANE_WIDTH, {k[0], 2'b11, codes[k]});
			check("lane mask", {lane_ok, lanes}, {1'b1, masks[k]});
			check("framing", enh, k[0]);
			rd_chk("lane back", ADDR_LANE_WIDTH, {k[0], 2'b00, codes[k]});
		end
		wr_settle(ADDR_LANE_WIDTH, 8'h03);
		check("lane reserved", {lane_ok, lanes}, 5'h00);
	endtask
	task automatic t_training();
		logic [1:0] v;
		logic [7:0] d;
		for (int k = 0; k < 4; k++) begin
			v = k[1:0];
			d = {v, v[0], ~v[0], ~v, v};
			wr_settle(ADDR_TRAINING, d);
			check("pattern", tpat, v);
			check("quality", qpat, 2'(~v));
			check("rclk", rclk, 1'(~v[0]));
			check("scramble", scr, v[0]);
			check("err sel", esel, v);
			rd_chk("training back", ADDR_TRAINING, d);
		end
	endtask
	task automatic t_drive();
		wr_settle(ADDR_DRIVE_BASE, 8'hFF);
		wr_settle(ADDR_DRIVE_BASE + 20'h0_0003, 8'hD5);
		check("drive out", drive, 32'h1500_003F);
		rd_chk("drive0 back", ADDR_DRIVE_BASE, 8'h3F);
		rd_chk("drive3 back", ADDR_DRIVE_BASE + 20'h0_0003, 8'h15);
	endtask
	task automatic t_status();
		@(posedge mclk_in);
		cr <= 4'hF;
		eq <= 4'h6;
		sl <= 4'h5;
		swing <= 8'hE4;
		emph <= 8'h1B;
		sync <= 2'b10;
		aligned <= 1'b1;
		ds <= 1'b1;
		@(posedge mclk_in);
		ds <= 1'b0;
		repeat (4) @(posedge mclk_in);
		rd_chk("align first", ADDR_ALIGN, 8'hC1);
		rd_chk("align again", ADDR_ALIGN, 8'h01);
		rd_chk("lanes low", ADDR_LANES_LOW, 8'h35);
		rd_chk("lanes high", ADDR_LANES_HIGH, 8'h17);
		rd_chk("sync", ADDR_SYNC, 8'h02);
		rd_chk("req low", ADDR_REQ_LOW, 8'h9C);
		rd_chk("req high", ADDR_REQ_HIGH, 8'h36);
		wr_settle(ADDR_LANES_LOW, 8'h00);
		wr_settle(ADDR_REQ_LOW, 8'hFF);
		rd_chk("lanes low kept", ADDR_LANES_LOW, 8'h35);
		rd_chk("req low kept", ADDR_REQ_LOW, 8'h9C);
		rd_chk("align quiet", ADDR_ALIGN, 8'h01);
	endtask
	initial begin
		repeat (20000) @(posedge mclk_in);
		failures++;
		results();
	end
	initial begin
		repeat (6) @(posedge mclk_in);
		srst_in <= 1'b0;
		t_reset();
		t_rate();
		t_lanes();
		t_training();
		t_drive();
		t_status();
		results();
	end
endmodule
`default_nettype wire
